// file: hdl/pcd_edge.sv
// Pin synchroniser and edge finder for one eight-bit port.
// Assumes the pins are board levels, possibly asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module pcd_edge (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Pins
	input wire logic [7:0] i_pins,
	// Edge pulses, one cycle each
	output logic [7:0] o_rise,
	output logic [7:0] o_fall
);

	pcd_pkg::pcd_edge_st_t st;
	pcd_pkg::pcd_edge_st_t next_st;

	////////////////////////////////////////////////////////////////////////
	// Two flops, then a history flop; valid hides the pipeline fill
	always_comb begin
		next_st = st;
		next_st.sync1 = i_pins;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		next_st.valid = {st.valid[1:0], 1'b1};
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st <= pcd_pkg::PCD_EDGE_RST;
		end else begin
			st <= next_st;
		end
	end

	// Compare current with previous sample
	assign o_rise = st.valid[pcd_pkg::PCD_SYNC_PRIME-1] ? (st.sync2 & ~st.prev) : 8'h00;
	assign o_fall = st.valid[pcd_pkg::PCD_SYNC_PRIME-1] ? (~st.sync2 & st.prev) : 8'h00;

endmodule

`default_nettype wire

// file: hdl/pcd_top.sv
// Pin change edge detector for three ports with Wishbone registers.
// Assumes synchronous active-high reset, one 50 MHz clock, pins from the board.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enabled rising edge on a pin sets that pin's change flag.
// - Enabled falling edge on a pin sets that pin's change flag.
// - A flag stays set until software writes zero to it.
// - Enabled edge sets the flag and its port's status bit; o_irq also needs that irq_mask bit and the interrupt enable.
// - A disabled polarity never sets the pin's flag.
// - Port A implements bits 0 to 5 only; bits 6 and 7 read zero.
// - Port B implements bits 4 to 7, and only in the 20-pin variant.
// - Port C implements all eight bits; bits 6 and 7 need 20-pin variant.
// - With the debugger enabled, port A bits 0 and 1 detect nothing.
// - Master clear or low-voltage programming removes detection on port A bit 3.
// - Flags keep being set with the interrupt enable clear; only the request and the wake stop.
// - Summary flag is the OR of every change flag of every port.
// - An edge during a clearing write leaves its flag set.
// - An edge in sleep updates flags and wakes, if interrupts are enabled.
module pcd_top #(
	parameter bit P_PIN20 = 1'b1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [15:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Port pins
	input wire logic [7:0] i_first_port_pin,
	input wire logic [7:0] i_second_port_pin,
	input wire logic [7:0] i_third_port_pin,
	// Power state
	input wire logic i_sleep,
	// Interrupt and status
	output logic o_irq,
	output logic o_change_summary,
	output logic o_wake
);

	pcd_pkg::pcd_state_t st;
	pcd_pkg::pcd_state_t next_st;
	pcd_pkg::pcd_cmd_t cmd;
	pcd_pkg::pcd_port_t pins;
	pcd_pkg::pcd_port_t rise;
	pcd_pkg::pcd_port_t fall;
	pcd_pkg::pcd_port_t impl;
	pcd_pkg::pcd_port_t en_ok;
	pcd_pkg::pcd_port_t rise_hit;
	pcd_pkg::pcd_port_t fall_hit;
	pcd_pkg::pcd_port_t set_vec;
	logic [7:0] a_lost;

	assign pins = {i_third_port_pin, i_second_port_pin, i_first_port_pin};

	////////////////////////////////////////////////////////////////////////
	// Bus front end
	pcd_wb_slave u_wb (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_wb_cyc(i_wb_cyc),
		.i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we),
		.i_wb_adr(i_wb_adr),
		.i_wb_dat(i_wb_dat),
		.i_wb_sel(i_wb_sel),
		.o_wb_ack(o_wb_ack),
		.o_cmd(cmd)
	);

	////////////////////////////////////////////////////////////////////////
	// Pins lost to debugger, master clear or low-voltage programming; enables still store the bits
	always_comb begin
		a_lost = 8'h00;
		if (st.cfg.debug_enable) begin
			a_lost = a_lost | pcd_pkg::PCD_A_DEBUG_MASK;
		end
		if (st.cfg.master_clear_pin_enable || st.cfg.low_voltage_program_enable) begin
			a_lost = a_lost | pcd_pkg::PCD_A_MCLR_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-port edge finders and qualification
	for (genvar gp = 0; gp < pcd_pkg::PCD_PORTS; gp++) begin : g_port
		pcd_edge u_edge (
			.i_clk(i_clk),
			.i_sys_rst(i_sys_rst),
			.i_pins(pins[gp]),
			.o_rise(rise[gp]),
			.o_fall(fall[gp])
		);
		assign impl[gp] = pcd_pkg::pcd_impl_mask(gp, P_PIN20);
		assign en_ok[gp] = (gp == pcd_pkg::PCD_PORT_A) ? (impl[gp] & ~a_lost) : impl[gp];
		// Disabled polarity contributes nothing
		assign rise_hit[gp] = rise[gp] & st.en_rise[gp] & en_ok[gp];
		assign fall_hit[gp] = fall[gp] & st.en_fall[gp] & en_ok[gp];
		assign set_vec[gp] = rise_hit[gp] | fall_hit[gp];
	end

	////////////////////////////////////////////////////////////////////////
	// Register file
	always_comb begin
		next_st = st;
		if (cmd.wr) begin
			if (cmd.idx == pcd_pkg::PCD_IDX_A_RISE) begin
				next_st.en_rise[pcd_pkg::PCD_PORT_A] = cmd.wdat & impl[pcd_pkg::PCD_PORT_A];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_A_FALL) begin
				next_st.en_fall[pcd_pkg::PCD_PORT_A] = cmd.wdat & impl[pcd_pkg::PCD_PORT_A];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_A_FLAG) begin
				next_st.flags[pcd_pkg::PCD_PORT_A] = cmd.wdat & impl[pcd_pkg::PCD_PORT_A];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_B_RISE) begin
				next_st.en_rise[pcd_pkg::PCD_PORT_B] = cmd.wdat & impl[pcd_pkg::PCD_PORT_B];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_B_FALL) begin
				next_st.en_fall[pcd_pkg::PCD_PORT_B] = cmd.wdat & impl[pcd_pkg::PCD_PORT_B];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_B_FLAG) begin
				next_st.flags[pcd_pkg::PCD_PORT_B] = cmd.wdat & impl[pcd_pkg::PCD_PORT_B];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_C_RISE) begin
				next_st.en_rise[pcd_pkg::PCD_PORT_C] = cmd.wdat & impl[pcd_pkg::PCD_PORT_C];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_C_FALL) begin
				next_st.en_fall[pcd_pkg::PCD_PORT_C] = cmd.wdat & impl[pcd_pkg::PCD_PORT_C];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_C_FLAG) begin
				next_st.flags[pcd_pkg::PCD_PORT_C] = cmd.wdat & impl[pcd_pkg::PCD_PORT_C];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_IRQ_STATUS) begin
				next_st.irq_status = st.irq_status & ~cmd.wdat[2:0];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_IRQ_MASK) begin
				next_st.irq_mask = cmd.wdat[2:0];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_IRQ_CTRL) begin
				next_st.change_irq_enable = cmd.wdat[0];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_CFG) begin
				next_st.cfg = pcd_pkg::pcd_cfg_t'(cmd.wdat[2:0]);
			end
		end
		// Hardware set wins over any write in the same cycle
		for (int p = 0; p < pcd_pkg::PCD_PORTS; p++) begin
			next_st.flags[p] = next_st.flags[p] | set_vec[p];
			next_st.irq_status[p] = next_st.irq_status[p] | (|set_vec[p]);
		end
		// Read data sampled at accept, shown with ack
		if (cmd.rd) begin
			if (cmd.idx == pcd_pkg::PCD_IDX_A_RISE) begin
				next_st.rdata = st.en_rise[pcd_pkg::PCD_PORT_A];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_A_FALL) begin
				next_st.rdata = st.en_fall[pcd_pkg::PCD_PORT_A];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_A_FLAG) begin
				next_st.rdata = st.flags[pcd_pkg::PCD_PORT_A];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_B_RISE) begin
				next_st.rdata = st.en_rise[pcd_pkg::PCD_PORT_B];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_B_FALL) begin
				next_st.rdata = st.en_fall[pcd_pkg::PCD_PORT_B];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_B_FLAG) begin
				next_st.rdata = st.flags[pcd_pkg::PCD_PORT_B];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_C_RISE) begin
				next_st.rdata = st.en_rise[pcd_pkg::PCD_PORT_C];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_C_FALL) begin
				next_st.rdata = st.en_fall[pcd_pkg::PCD_PORT_C];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_C_FLAG) begin
				next_st.rdata = st.flags[pcd_pkg::PCD_PORT_C];
			end else if (cmd.idx == pcd_pkg::PCD_IDX_IRQ_STATUS) begin
				next_st.rdata = {5'h00, st.irq_status};
			end else if (cmd.idx == pcd_pkg::PCD_IDX_IRQ_MASK) begin
				next_st.rdata = {5'h00, st.irq_mask};
			end else if (cmd.idx == pcd_pkg::PCD_IDX_IRQ_CTRL) begin
				next_st.rdata = {7'h00, st.change_irq_enable};
			end else if (cmd.idx == pcd_pkg::PCD_IDX_CFG) begin
				next_st.rdata = {5'h00, st.cfg};
			end else begin
				next_st.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st <= pcd_pkg::PCD_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_wb_dat = {24'h000000, st.rdata};
	assign o_change_summary = (st.flags != '0);
	// Gate only the request; flags keep collecting
	assign o_irq = st.change_irq_enable && ((st.irq_status & st.irq_mask) != 3'h0);
	// Flags are already updated when wake rises, so code sees them at once
	assign o_wake = i_sleep && st.change_irq_enable && o_change_summary;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	rise_flag_a: assert property ((rise_hit != '0) |=> ((st.flags & $past(rise_hit)) == $past(rise_hit)))
		else $error("enabled rising edge did not set its flag");

	fall_flag_a: assert property ((fall_hit != '0) |=> ((st.flags & $past(fall_hit)) == $past(fall_hit)))
		else $error("enabled falling edge did not set its flag");

	flag_hold_a: assert property (!cmd.wr |=> ((st.flags & $past(st.flags)) == $past(st.flags)))
		else $error("change flag dropped without a write");

	irq_arm_a: assert property (((set_vec[0] != 8'h00) && st.irq_mask[0] && st.change_irq_enable && !cmd.wr) |=> o_irq)
		else $error("armed edge did not raise the interrupt");

	no_stray_a: assert property (!$past(cmd.wr) |-> ((st.flags & ~$past(st.flags) & ~$past(set_vec)) == '0))
		else $error("flag set without a qualified edge");

	port_a_width_a: assert property ((st.flags[0][7:6] == 2'h0) && (st.en_rise[0][7:6] == 2'h0) && (st.en_fall[0][7:6] == 2'h0))
		else $error("unimplemented port A bits hold a one");

	port_b_width_a: assert property (((st.flags[1] | st.en_rise[1] | st.en_fall[1]) & ~impl[1]) == 8'h00)
		else $error("unimplemented port B bits hold a one");

	port_c_width_a: assert property (((st.flags[2] | st.en_rise[2] | st.en_fall[2]) & ~impl[2]) == 8'h00)
		else $error("unimplemented port C bits hold a one");

	debug_block_a: assert property ((st.cfg.debug_enable && $past(st.cfg.debug_enable) && !$past(cmd.wr)) |-> ((st.flags[0] & ~$past(st.flags[0]) & pcd_pkg::PCD_A_DEBUG_MASK) == 8'h00))
		else $error("debugger pins reported a change");

	mclr_block_a: assert property (($past(st.cfg.master_clear_pin_enable || st.cfg.low_voltage_program_enable) && !$past(cmd.wr)) |-> ((st.flags[0] & ~$past(st.flags[0]) & pcd_pkg::PCD_A_MCLR_MASK) == 8'h00))
		else $error("master clear pin reported a change");

	irq_gate_a: assert property (((set_vec != '0) && !st.change_irq_enable && !cmd.wr) |=> (o_change_summary && !o_irq))
		else $error("disabled interrupt blocked flags or still fired");

	summary_rise_a: assert property ($rose(o_change_summary) |-> ($past(set_vec != '0) || $past(cmd.wr)))
		else $error("summary rose without cause");

	clear_race_a: assert property ((cmd.wr && (cmd.idx == pcd_pkg::PCD_IDX_A_FLAG) && (set_vec[0] != 8'h00)) |=> ((st.flags[0] & $past(set_vec[0])) == $past(set_vec[0])))
		else $error("edge lost during flag clear");

	wake_a: assert property ((i_sleep && st.change_irq_enable && (set_vec != '0) && !cmd.wr) |=> (o_wake || !i_sleep))
		else $error("edge in sleep did not wake");

	sequence s_pin_rise;
		$rose(i_first_port_pin[2]) && st.en_rise[0][2] && !cmd.wr;
	endsequence

	sequence s_pin_held;
		(i_first_port_pin[2] && !cmd.wr)[*3];
	endsequence

	sync_delay_a: assert property ((s_pin_rise ##0 s_pin_held) |-> ##[0:1] st.flags[0][2])
		else $error("synchronised rise not flagged in time");

	// Reset seen now, zeros checked one edge later; no $past needed at time zero
	reset_zero_a: assert property (@(posedge i_clk) disable iff (1'b0) i_sys_rst |=> ((st.flags == '0) && (st.en_rise == '0) && (st.en_fall == '0)))
		else $error("enables or flags not zero after reset");

endmodule

`default_nettype wire

// file: hdl/pcd_wb_slave.sv
// Classic Wishbone slave front end: accepts one request, acks one cycle later.
// Assumes the master holds its request until it samples ack.
`timescale 1ns/1ps
`default_nettype none

module pcd_wb_slave (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [15:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic o_wb_ack,
	// Command to the register file
	output pcd_pkg::pcd_cmd_t o_cmd
);

	pcd_pkg::pcd_wb_st_t st;
	pcd_pkg::pcd_wb_st_t next_st;
	logic accept;

	// Idle only, so a held request is never taken twice
	assign accept = i_wb_cyc && i_wb_stb && (st.state == pcd_pkg::PCD_WB_IDLE);

	always_comb begin
		next_st = st;
		case (st.state)
			pcd_pkg::PCD_WB_IDLE: begin
				if (accept) begin
					next_st.state = pcd_pkg::PCD_WB_ACK;
				end
			end
			default: begin
				next_st.state = pcd_pkg::PCD_WB_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st <= pcd_pkg::PCD_WB_RST;
		end else begin
			st <= next_st;
		end
	end

	// Only lane 0 carries data
	assign o_cmd.wr = accept && i_wb_we && i_wb_sel[0];
	assign o_cmd.rd = accept && !i_wb_we;
	assign o_cmd.idx = i_wb_adr[15:2];
	assign o_cmd.wdat = i_wb_dat[7:0];
	assign o_wb_ack = (st.state == pcd_pkg::PCD_WB_ACK);

endmodule

`default_nettype wire

// file: include/pcd_pkg.sv
// Package for the pin change edge detector: register indices, field masks,
// reset values and the structs that carry state and bus commands.
// Assumes a 32-bit classic Wishbone slave port and a 50 MHz system clock.
package pcd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int PCD_PORTS = 3;
	localparam int PCD_PORT_A = 0;
	localparam int PCD_PORT_B = 1;
	localparam int PCD_PORT_C = 2;
	localparam int PCD_IDX_W = 14;
	localparam int PCD_SYNC_PRIME = 3;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [13:0] PCD_IDX_A_RISE = 14'h1F3D;
	localparam logic [13:0] PCD_IDX_A_FALL = 14'h1F3E;
	localparam logic [13:0] PCD_IDX_A_FLAG = 14'h1F3F;
	localparam logic [13:0] PCD_IDX_B_RISE = 14'h1F48;
	localparam logic [13:0] PCD_IDX_B_FALL = 14'h1F49;
	localparam logic [13:0] PCD_IDX_B_FLAG = 14'h1F4A;
	localparam logic [13:0] PCD_IDX_C_RISE = 14'h1F53;
	localparam logic [13:0] PCD_IDX_C_FALL = 14'h1F54;
	localparam logic [13:0] PCD_IDX_C_FLAG = 14'h1F55;
	localparam logic [13:0] PCD_IDX_IRQ_STATUS = 14'h1F60;
	localparam logic [13:0] PCD_IDX_IRQ_MASK = 14'h1F61;
	localparam logic [13:0] PCD_IDX_IRQ_CTRL = 14'h1F62;
	localparam logic [13:0] PCD_IDX_CFG = 14'h1F63;

	////////////////////////////////////////////////////////////////////////
	// Implemented bits and pins lost to other functions
	localparam logic [7:0] PCD_IMPL_A = 8'h3F;
	localparam logic [7:0] PCD_IMPL_B = 8'hF0;
	localparam logic [7:0] PCD_IMPL_C_FULL = 8'hFF;
	localparam logic [7:0] PCD_IMPL_C_SMALL = 8'h3F;
	localparam logic [7:0] PCD_IMPL_NONE = 8'h00;
	localparam logic [7:0] PCD_A_DEBUG_MASK = 8'h03;
	localparam logic [7:0] PCD_A_MCLR_MASK = 8'h08;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef logic [2:0][7:0] pcd_port_t;

	typedef struct packed {
		logic low_voltage_program_enable;
		logic master_clear_pin_enable;
		logic debug_enable;
	} pcd_cfg_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [13:0] idx;
		logic [7:0] wdat;
	} pcd_cmd_t;

	typedef struct packed {
		pcd_port_t en_rise;
		pcd_port_t en_fall;
		pcd_port_t flags;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic change_irq_enable;
		pcd_cfg_t cfg;
		logic [7:0] rdata;
	} pcd_state_t;

	typedef enum logic [1:0] {
		PCD_WB_IDLE = 2'b00,
		PCD_WB_ACK = 2'b01
	} pcd_wb_state_t;

	typedef struct packed {
		pcd_wb_state_t state;
	} pcd_wb_st_t;

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [2:0] valid;
	} pcd_edge_st_t;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam pcd_state_t PCD_STATE_RST = '0;
	localparam pcd_wb_st_t PCD_WB_RST = '{state: PCD_WB_IDLE};
	localparam pcd_edge_st_t PCD_EDGE_RST = '0;

	// Implemented bits of a port, used for enables, flags and reads
	function automatic logic [7:0] pcd_impl_mask(input int port, input bit pin20);
		logic [7:0] m;
		m = PCD_IMPL_NONE;
		if (port == PCD_PORT_A) begin
			m = PCD_IMPL_A;
		end else if (port == PCD_PORT_B) begin
			m = pin20 ? PCD_IMPL_B : PCD_IMPL_NONE;
		end else if (port == PCD_PORT_C) begin
			m = pin20 ? PCD_IMPL_C_FULL : PCD_IMPL_C_SMALL;
		end
		return m;
	endfunction

endpackage

// file: verif/pcd_pin_model.sv
// Board-side model of the three port pin groups.
// Assumes the bench moves the levels through set_pins from its own sequence.
`timescale 1ns/1ps
`default_nettype none

module pcd_pin_model (
	// Clock
	input wire logic i_clk,
	// Pins towards the block
	output logic [7:0] o_first_port_pin,
	output logic [7:0] o_second_port_pin,
	output logic [7:0] o_third_port_pin
);
	pcd_pkg::pcd_port_t lvl = '0;

	assign o_first_port_pin = lvl[0];
	assign o_second_port_pin = lvl[1];
	assign o_third_port_pin = lvl[2];

	////////////////////////////////////////////////////////////////////////
	// Levels move just after an edge and hold for whole cycles,
	// so no pulse is shorter than the block can see
	task automatic set_pins(input pcd_pkg::pcd_port_t v);
		@(posedge i_clk);
		lvl <= v;
	endtask
endmodule

`default_nettype wire

// file: verif/pcd_top_tb.sv
// Self-checking bench for the pin change edge detector.
// Assumes the 20-pin variant and the board model pcd_pin_model.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("[ERR] %s expected %h seen %h", nm, (exp), (got)); \
	end \
end

module pcd_top_tb;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [15:0] wb_adr = 16'h0000;
	logic [31:0] wb_dat = 32'h00000000;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic sleep = 1'b0;
	logic irq;
	logic summary;
	logic wake;
	logic [7:0] pin_a;
	logic [7:0] pin_b;
	logic [7:0] pin_c;
	int bad_count = 0;
	int checks = 0;

	always #10 i_clk = ~i_clk;

	pcd_pin_model pm (
		.i_clk(i_clk),
		.o_first_port_pin(pin_a),
		.o_second_port_pin(pin_b),
		.o_third_port_pin(pin_c)
	);

	pcd_top #(.P_PIN20(1'b1)) dut (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_wb_cyc(wb_cyc),
		.i_wb_stb(wb_stb),
		.i_wb_we(wb_we),
		.i_wb_adr(wb_adr),
		.i_wb_dat(wb_dat),
		.i_wb_sel(wb_sel),
		.o_wb_dat(wb_rdat),
		.o_wb_ack(wb_ack),
		.i_first_port_pin(pin_a),
		.i_second_port_pin(pin_b),
		.i_third_port_pin(pin_c),
		.i_sleep(sleep),
		.o_irq(irq),
		.o_change_summary(summary),
		.o_wake(wake)
	);

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Request held until ack is sampled; data taken at that same edge
	task automatic wb_xfer(input logic we, input logic [13:0] idx, input logic [7:0] d,
			input logic [3:0] sel, output logic [31:0] rd);
		int n;
		@(posedge i_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_dat <= {24'h000000, d};
		wb_sel <= sel;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 16);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		`CHK("wb_ack", 1'b1, wb_ack)
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		wb_xfer(1'b1, idx, d, 4'h1, rd);
	endtask

	task automatic rdc(input string nm, input logic [13:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		wb_xfer(1'b0, idx, 8'h00, 4'h1, rd);
		`CHK(nm, {24'h000000, exp}, rd)
	endtask

	task automatic pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		pm.set_pins({c, b, a});
	endtask

	// Flag lands three edges after a pin move; one spare edge
	task automatic settle();
		repeat (4) @(posedge i_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset_vals();
		logic [13:0] idx [13];
		idx = '{pcd_pkg::PCD_IDX_A_RISE, pcd_pkg::PCD_IDX_A_FALL, pcd_pkg::PCD_IDX_A_FLAG,
			pcd_pkg::PCD_IDX_B_RISE, pcd_pkg::PCD_IDX_B_FALL, pcd_pkg::PCD_IDX_B_FLAG,
			pcd_pkg::PCD_IDX_C_RISE, pcd_pkg::PCD_IDX_C_FALL, pcd_pkg::PCD_IDX_C_FLAG,
			pcd_pkg::PCD_IDX_IRQ_STATUS, pcd_pkg::PCD_IDX_IRQ_MASK,
			pcd_pkg::PCD_IDX_IRQ_CTRL, pcd_pkg::PCD_IDX_CFG};
		foreach (idx[i]) begin
			rdc("reset value", idx[i], 8'h00);
		end
		rdc("unmapped", 14'h0000, 8'h00);
		`CHK("irq at reset", 1'b0, irq)
	endtask

	task automatic t_widths();
		logic [31:0] rd;
		wr(pcd_pkg::PCD_IDX_A_RISE, 8'hFF);
		rdc("a rise width", pcd_pkg::PCD_IDX_A_RISE, 8'h3F);
		wr(pcd_pkg::PCD_IDX_B_RISE, 8'hFF);
		rdc("b rise width", pcd_pkg::PCD_IDX_B_RISE, 8'hF0);
		wr(pcd_pkg::PCD_IDX_C_FALL, 8'hFF);
		rdc("c fall width", pcd_pkg::PCD_IDX_C_FALL, 8'hFF);
		wb_xfer(1'b1, pcd_pkg::PCD_IDX_C_RISE, 8'hFF, 4'h0, rd);
		rdc("lane off write", pcd_pkg::PCD_IDX_C_RISE, 8'h00);
		wr(pcd_pkg::PCD_IDX_A_RISE, 8'h00);
		wr(pcd_pkg::PCD_IDX_B_RISE, 8'h00);
		wr(pcd_pkg::PCD_IDX_C_FALL, 8'h00);
	endtask

	task automatic t_rise_c();
		wr(pcd_pkg::PCD_IDX_C_RISE, 8'hFF);
		pins(8'h00, 8'h00, 8'hFF);
		settle();
		rdc("c flags rise", pcd_pkg::PCD_IDX_C_FLAG, 8'hFF);
		`CHK("summary set", 1'b1, summary)
		wr(pcd_pkg::PCD_IDX_C_FLAG, 8'h00);
		rdc("c flags cleared", pcd_pkg::PCD_IDX_C_FLAG, 8'h00);
		`CHK("summary clear", 1'b0, summary)
		pins(8'h00, 8'h00, 8'h00);
		settle();
		rdc("c fall disabled", pcd_pkg::PCD_IDX_C_FLAG, 8'h00);
		wr(pcd_pkg::PCD_IDX_C_RISE, 8'h00);
	endtask

	task automatic t_fall_b();
		wr(pcd_pkg::PCD_IDX_B_FALL, 8'hF0);
		pins(8'h00, 8'hFF, 8'h00);
		settle();
		rdc("b rise disabled", pcd_pkg::PCD_IDX_B_FLAG, 8'h00);
		pins(8'h00, 8'h00, 8'h00);
		settle();
		rdc("b flags fall", pcd_pkg::PCD_IDX_B_FLAG, 8'hF0);
		wr(pcd_pkg::PCD_IDX_B_FALL, 8'h00);
		settle();
		rdc("b flags sticky", pcd_pkg::PCD_IDX_B_FLAG, 8'hF0);
		wr(pcd_pkg::PCD_IDX_B_FLAG, 8'h00);
	endtask

	task automatic t_irq();
		// Earlier scenarios left port B and C status bits set
		wr(pcd_pkg::PCD_IDX_IRQ_STATUS, 8'h07);
		rdc("status cleared", pcd_pkg::PCD_IDX_IRQ_STATUS, 8'h00);
		wr(pcd_pkg::PCD_IDX_C_RISE, 8'h01);
		wr(pcd_pkg::PCD_IDX_IRQ_MASK, 8'h04);
		pins(8'h00, 8'h00, 8'h01);
		settle();
		rdc("flag with ie off", pcd_pkg::PCD_IDX_C_FLAG, 8'h01);
		rdc("irq status", pcd_pkg::PCD_IDX_IRQ_STATUS, 8'h04);
		`CHK("irq gated", 1'b0, irq)
		wr(pcd_pkg::PCD_IDX_IRQ_CTRL, 8'h01);
		`CHK("irq raised", 1'b1, irq)
		sleep <= 1'b1;
		@(posedge i_clk);
		`CHK("wake", 1'b1, wake)
		wr(pcd_pkg::PCD_IDX_IRQ_MASK, 8'h00);
		`CHK("irq masked", 1'b0, irq)
		wr(pcd_pkg::PCD_IDX_C_FLAG, 8'h00);
		wr(pcd_pkg::PCD_IDX_IRQ_STATUS, 8'h04);
		wr(pcd_pkg::PCD_IDX_IRQ_MASK, 8'h04);
		`CHK("irq cleared", 1'b0, irq)
		`CHK("wake cleared", 1'b0, wake)
		sleep <= 1'b0;
		wr(pcd_pkg::PCD_IDX_C_RISE, 8'h00);
	endtask

	task automatic t_lost_pins();
		wr(pcd_pkg::PCD_IDX_CFG, 8'h03);
		wr(pcd_pkg::PCD_IDX_A_RISE, 8'h3F);
		pins(8'h3F, 8'h00, 8'h01);
		settle();
		rdc("debug and clear pin", pcd_pkg::PCD_IDX_A_FLAG, 8'h34);
		wr(pcd_pkg::PCD_IDX_A_FLAG, 8'h00);
		wr(pcd_pkg::PCD_IDX_CFG, 8'h04);
		pins(8'h00, 8'h00, 8'h01);
		settle();
		pins(8'h3F, 8'h00, 8'h01);
		settle();
		rdc("low voltage prog", pcd_pkg::PCD_IDX_A_FLAG, 8'h37);
		wr(pcd_pkg::PCD_IDX_A_FLAG, 8'h00);
		wr(pcd_pkg::PCD_IDX_A_RISE, 8'h00);
		wr(pcd_pkg::PCD_IDX_CFG, 8'h00);
	endtask

	// Clearing write taken at the very edge where the pin's flag is set
	task automatic t_race();
		wr(pcd_pkg::PCD_IDX_C_RISE, 8'h02);
		pins(8'h00, 8'h00, 8'h03);
		@(posedge i_clk);
		wr(pcd_pkg::PCD_IDX_C_FLAG, 8'h00);
		settle();
		rdc("set beats clear", pcd_pkg::PCD_IDX_C_FLAG, 8'h02);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		rdc("flag after reset", pcd_pkg::PCD_IDX_C_FLAG, 8'h00);
		rdc("enable after reset", pcd_pkg::PCD_IDX_C_RISE, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		t_reset_vals();
		t_widths();
		t_rise_c();
		t_fall_b();
		t_irq();
		t_lost_pins();
		t_race();
		stop_test();
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		bad_count++;
		stop_test();
	end
endmodule

`default_nettype wire
